// ### design/tbpsm_pkg.sv
// What this block does
// - Three shared pins: transmit, receive, serial clock
// - Direction bit one drives, zero receives
// - Direction register write-only, reserved bits read one
// - Reset and hardware standby load 0xF8
// - Software standby keeps both registers
// - Software standby drops serial, pins revert
// - Data bits 2..0 stored; 7..3 read one
// - Port read: output data or live pin
// - Same pin choices in every chip mode
// - Serial function overrides direction bit
// - Pin 2 clock in/out per clock enables
// - Pin 1 receive, pin 0 transmit when enabled
package tbpsm_pkg;

  localparam int PORT_W = 3;
  localparam int ADDR_W = 20;

  // Printed offsets are register indices; bytes sit four apart
  localparam logic [15:0] PIN_DIR_IDX  = 16'hFFB8;
  localparam logic [15:0] PIN_OUT_IDX  = 16'hFFBA;
  localparam logic [ADDR_W-1:0] PIN_DIR_ADDR = {2'b00, PIN_DIR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] PIN_OUT_ADDR = {2'b00, PIN_OUT_IDX, 2'b00};

  localparam logic [7:0] PORT_RST     = 8'hF8;
  localparam logic [4:0] RSV_ONES     = 5'h1F;
  localparam logic [7:0] DIR_READ_VAL = 8'hFF;
  localparam int         RSV_LSB      = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Controls owned by the serial channel, same clock
  typedef struct packed {
    logic sync_mode;
    logic clock_enable_1;
    logic clock_enable_0;
    logic receive_enable_bit;
    logic transmit_enable_bit;
  } tbpsm_ser_t;

endpackage

// ### design/tbpsm_top.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tbpsm_top (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address
  input  wire logic [tbpsm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output var  logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output var  logic                         s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]                   s_axi_bresp,
  output var  logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [tbpsm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output var  logic                         s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0]                  s_axi_rdata,
  output var  logic [1:0]                   s_axi_rresp,
  output var  logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Power state
  input  wire logic                         hw_standby,
  input  wire logic                         sw_standby,
  // Serial channel side
  input  wire tbpsm_pkg::tbpsm_ser_t        ser_ctl,
  input  wire logic                         ser_txd,
  input  wire logic                         ser_sck_out,
  output var  logic                         serial_receive_pin,
  output var  logic                         serial_clock_pin,
  output var  logic                         ser_reset,
  // Pads
  input  wire logic [tbpsm_pkg::PORT_W-1:0] pin_in,
  output var  logic [tbpsm_pkg::PORT_W-1:0] pin_out,
  output var  logic [tbpsm_pkg::PORT_W-1:0] pin_oe
);
  import tbpsm_pkg::*;

  logic [PORT_W-1:0] dir_r;
  logic [PORT_W-1:0] dr_r;
  logic [PORT_W-1:0] sync1_r;
  logic [PORT_W-1:0] sync2_r;
  logic [PORT_W-1:0] sync3_r;
  logic [PORT_W-1:0] pin_lvl_r;
  logic [PORT_W-1:0] oe_nxt;
  logic [PORT_W-1:0] out_nxt;
  logic [PORT_W-1:0] port_rd;

  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        wdata_r;
  logic              wstrb0_r;
  logic              wr_en;
  logic              wr_dir;
  logic              wr_dr;
  logic              rd_dir;
  logic              rd_dr;

  logic              tx_act;
  logic              rx_act;
  logic              sck_in_act;
  logic              sck_out_act;

  // Chip operating mode has no input at all
  // Software standby resets the channel, so ownership drops
  assign tx_act      = ser_ctl.transmit_enable_bit & ~sw_standby;
  assign rx_act      = ser_ctl.receive_enable_bit & ~sw_standby;
  assign sck_in_act  = ser_ctl.clock_enable_1 & ~sw_standby;
  assign sck_out_act = ~ser_ctl.clock_enable_1 & ~sw_standby &
                       (ser_ctl.sync_mode | ser_ctl.clock_enable_0);

  // Pad input synchronisers, filtered on stage agreement
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_r[gi]   <= 1'b0;
          sync2_r[gi]   <= 1'b0;
          sync3_r[gi]   <= 1'b0;
          pin_lvl_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            pin_lvl_r[gi] <= sync3_r[gi];
          end
        end
      end
      // Output pins read back the stored bit
      assign port_rd[gi] = dir_r[gi] ? dr_r[gi] : pin_lvl_r[gi];
    end
  endgenerate

  // Pin function select, serial first
  always_comb begin
    oe_nxt  = dir_r;
    out_nxt = dr_r;
    if (tx_act) begin
      oe_nxt[0]  = 1'b1;
      out_nxt[0] = ser_txd;
    end
    if (rx_act) begin
      oe_nxt[1] = 1'b0;
    end
    if (sck_in_act) begin
      oe_nxt[2] = 1'b0;
    end else if (sck_out_act) begin
      oe_nxt[2]  = 1'b1;
      out_nxt[2] = ser_sck_out;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      pin_oe  <= oe_nxt;
      pin_out <= out_nxt;
    end
  end

  // Serial inputs are seen even when the pin is not theirs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_receive_pin <= 1'b0;
      serial_clock_pin   <= 1'b0;
      ser_reset          <= 1'b1;
    end else begin
      serial_receive_pin <= pin_lvl_r[1];
      serial_clock_pin   <= pin_lvl_r[2];
      ser_reset          <= sw_standby | hw_standby;
    end
  end

  // Write channel: address and data accepted in either order
  assign wr_en  = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_dir = aw_addr_r[ADDR_W-1:2] == PIN_DIR_ADDR[ADDR_W-1:2];
  assign wr_dr  = aw_addr_r[ADDR_W-1:2] == PIN_OUT_ADDR[ADDR_W-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_en) begin
      aw_held_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      wdata_r      <= '0;
      wstrb0_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      wdata_r      <= s_axi_wdata[7:0];
      wstrb0_r     <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_en) begin
      w_held_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_dir | wr_dr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reserved bits are not stored; software standby keeps state, hardware standby reloads the reset value
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      dir_r <= PORT_RST[PORT_W-1:0];
    end else if (wr_en && wr_dir && wstrb0_r) begin
      dir_r <= wdata_r[PORT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      dr_r <= PORT_RST[PORT_W-1:0];
    end else if (wr_en && wr_dr && wstrb0_r) begin
      dr_r <= wdata_r[PORT_W-1:0];
    end
  end

  // Read channel: one read at a time, answered one edge later
  assign rd_dir = s_axi_araddr[ADDR_W-1:2] == PIN_DIR_ADDR[ADDR_W-1:2];
  assign rd_dr  = s_axi_araddr[ADDR_W-1:2] == PIN_OUT_ADDR[ADDR_W-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      if (rd_dir) begin
        // Write-only: the value means nothing, low byte reads all ones, upper bytes zero
        s_axi_rdata[7:0] <= DIR_READ_VAL;
      end else if (rd_dr) begin
        s_axi_rdata[7:0] <= {RSV_ONES, port_rd};
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  property p_rx_input;
    @(posedge aclk) disable iff (!aresetn)
    rx_act |=> !pin_oe[1];
  endproperty
  a_rx_input: assert property (p_rx_input)
    else $error("receive pin driven while receive enabled");

  property p_tx_drive;
    @(posedge aclk) disable iff (!aresetn)
    tx_act |=> pin_oe[0] && (pin_out[0] == $past(ser_txd));
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("transmit pin not carrying serial data");

  property p_sck_in;
    @(posedge aclk) disable iff (!aresetn)
    sck_in_act |=> !pin_oe[2];
  endproperty
  a_sck_in: assert property (p_sck_in)
    else $error("clock pin driven while clock is an input");

  property p_sck_out;
    @(posedge aclk) disable iff (!aresetn)
    sck_out_act |=> pin_oe[2] && (pin_out[2] == $past(ser_sck_out));
  endproperty
  a_sck_out: assert property (p_sck_out)
    else $error("clock pin not driving serial clock");

  property p_gpio_bit0;
    @(posedge aclk) disable iff (!aresetn)
    !tx_act |=> pin_oe[0] == $past(dir_r[0]) &&
                (!pin_oe[0] || pin_out[0] == $past(dr_r[0]));
  endproperty
  a_gpio_bit0: assert property (p_gpio_bit0)
    else $error("general pin does not follow its registers");

  property p_reset_val;
    @(posedge aclk)
    !aresetn |=> dir_r == PORT_RST[PORT_W-1:0] &&
                 dr_r == PORT_RST[PORT_W-1:0] && pin_oe == '0;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("registers not at reset value after reset");

  property p_hw_standby;
    @(posedge aclk) disable iff (!aresetn)
    hw_standby |=> dir_r == '0 && dr_r == '0 ##1 !pin_oe[1];
  endproperty
  a_hw_standby: assert property (p_hw_standby)
    else $error("hardware standby did not clear direction");

  property p_sw_keep;
    @(posedge aclk) disable iff (!aresetn)
    sw_standby && !hw_standby && !wr_en |=> $stable(dir_r) && $stable(dr_r);
  endproperty
  a_sw_keep: assert property (p_sw_keep)
    else $error("registers changed in software standby");

  property p_sw_revert;
    @(posedge aclk) disable iff (!aresetn)
    sw_standby |=> ser_reset && pin_oe == $past(dir_r);
  endproperty
  a_sw_revert: assert property (p_sw_revert)
    else $error("pins not returned to general use in standby");

  property p_rd_rsv;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && rd_dr |=>
      s_axi_rvalid && s_axi_rdata[7:RSV_LSB] == RSV_ONES;
  endproperty
  a_rd_rsv: assert property (p_rd_rsv)
    else $error("reserved data bits did not read as one");

  property p_rd_dir;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && rd_dir |=>
      s_axi_rdata[7:0] == DIR_READ_VAL;
  endproperty
  a_rd_dir: assert property (p_rd_dir)
    else $error("direction read did not return all ones");

endmodule
`default_nettype wire

// ### tb/tbpsm_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbpsm_pad_model (
  // Clock
  input  wire logic                         aclk,
  // Device side of the pads
  input  wire logic [tbpsm_pkg::PORT_W-1:0] pin_out,
  input  wire logic [tbpsm_pkg::PORT_W-1:0] pin_oe,
  // Far-end drivers
  input  wire logic [tbpsm_pkg::PORT_W-1:0] ext_en,
  input  wire logic [tbpsm_pkg::PORT_W-1:0] ext_val,
  // Resolved pad levels
  output var  logic [tbpsm_pkg::PORT_W-1:0] pin_in
);
  import tbpsm_pkg::*;
  logic [PORT_W-1:0] last_r = '0;
  // Floating pad flips each cycle so a held value never passes
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] :
                  ext_en[i] ? ext_val[i] : ~last_r[i];
    end
  end
  always_ff @(posedge aclk) begin
    last_r <= pin_in;
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tbpsm_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata, d;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, r;
  logic              hw_sb = 1'b0, sw_sb = 1'b0, txd = 1'b0, sck = 1'b0;
  tbpsm_ser_t        ser = '0;
  logic              rx_pin, ck_pin, ser_rst;
  logic [PORT_W-1:0] pin_in, pin_out, pin_oe;
  logic [PORT_W-1:0] ext_en = '1, ext_val = '0;
  int                errors = 0, compares = 0;
  logic [4:0]        t_ctl [7] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h18,
                                   5'h10, 5'h04};
  logic [5:0]        t_exp [7] = '{6'h38, 6'h39, 6'h28, 6'h18, 6'h18,
                                   6'h3C, 6'h3C};

  always #12.5 aclk = ~aclk;

  tbpsm_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hw_standby(hw_sb), .sw_standby(sw_sb), .ser_ctl(ser),
    .ser_txd(txd), .ser_sck_out(sck), .serial_receive_pin(rx_pin),
    .serial_clock_pin(ck_pin), .ser_reset(ser_rst),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  tbpsm_pad_model pads (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Valids held until their own ready; answer awaited under a bound
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 20) begin
      errors++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 20) begin
      errors++;
      end_sim();
    end
  endtask

  task automatic rchk(input string n, input logic [ADDR_W-1:0] a,
                      input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    chk(n, e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic pchk(input logic [5:0] e);
    chk("pins", {26'h0, e}, {26'h0, pin_oe, pin_out & pin_oe});
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("port", PIN_OUT_ADDR, 32'h0000_00F8, RESP_OKAY);
    rchk("dir", PIN_DIR_ADDR, 32'h0000_00FF, RESP_OKAY);
    pchk(6'h00);
    chk("ser_reset", 32'h0, {31'h0, ser_rst});
    wr(PIN_DIR_ADDR, 32'h0000_0005, r);
    wr(PIN_OUT_ADDR, 32'h0000_00FF, r);
    #1 pchk(6'h2D);
    rchk("port", PIN_OUT_ADDR, 32'h0000_00FD, RESP_OKAY);
    ext_val <= 3'b010;
    repeat (6) @(posedge aclk);
    rchk("port", PIN_OUT_ADDR, 32'h0000_00FF, RESP_OKAY);
    wr(20'h0_0010, 32'h0000_0001, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rchk("void", 20'h0_0010, 32'h0000_0000, RESP_SLVERR);
    // Every serial ownership case against an all-output port
    wr(PIN_DIR_ADDR, 32'h0000_0007, r);
    wr(PIN_OUT_ADDR, 32'h0000_0000, r);
    txd <= 1'b1;
    sck <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      ser <= tbpsm_ser_t'(t_ctl[i]);
      @(posedge aclk);
      #1 pchk(t_exp[i]);
    end
    @(posedge aclk);
    ser <= tbpsm_ser_t'(5'h0A);
    // Far end opposes what the port last drove on pins 1 and 2
    ext_val <= 3'b010;
    repeat (7) @(posedge aclk);
    chk("rx", 32'h1, {31'h0, rx_pin});
    chk("sck", 32'h0, {31'h0, ck_pin});
    rchk("port", PIN_OUT_ADDR, 32'h0000_00F8, RESP_OKAY);
    wr(PIN_OUT_ADDR, 32'h0000_0002, r);
    ser <= tbpsm_ser_t'(5'h01);
    sw_sb <= 1'b1;
    repeat (2) @(posedge aclk);
    #1 pchk(6'h3A);
    chk("ser_reset", 32'h1, {31'h0, ser_rst});
    rchk("port", PIN_OUT_ADDR, 32'h0000_00FA, RESP_OKAY);
    @(posedge aclk);
    sw_sb <= 1'b0;
    ser <= '0;
    hw_sb <= 1'b1;
    ext_en <= '1;
    ext_val <= '0;
    repeat (2) @(posedge aclk);
    hw_sb <= 1'b0;
    @(posedge aclk);
    #1 pchk(6'h00);
    // Released pins need the input filter's latency
    repeat (4) @(posedge aclk);
    rchk("port", PIN_OUT_ADDR, 32'h0000_00F8, RESP_OKAY);
    end_sim();
  end
endmodule
`default_nettype wire
